/* cscr_pkg.sv */
/*
 * Shared definitions for the charger status and control register tail:
 * register offsets, field positions, reset values, watchdog timing and the
 * packed carriers for the analog condition inputs.
 * Assumes an 8-bit register address and 8-bit register data.
 */
package cscr_pkg;

    // Register offsets.
    localparam logic [7:0] MISC_OFFSET   = 8'h06;
    localparam logic [7:0] STATUS_OFFSET = 8'h07;
    localparam logic [7:0] FAULT_OFFSET  = 8'h08;

    // Control register fields and reset value.
    localparam int         MISC_TMR2X_BIT  = 6;
    localparam int         MISC_BSW_BIT    = 5;
    localparam int         MISC_NTC_BIT    = 3;
    localparam int         MISC_TJ_LSB     = 0;
    localparam logic [7:0] MISC_RESET      = 8'h4b;
    localparam logic [7:0] MISC_WRITE_MASK = 8'h6b;

    // Status register field positions.
    localparam int STAT_REV_LSB   = 5;
    localparam int STAT_CHG_LSB   = 3;
    localparam int STAT_PPM_BIT   = 2;
    localparam int STAT_PG_BIT    = 1;
    localparam int STAT_THERM_BIT = 0;

    // Fault register field positions and reset value.
    localparam int         FLT_WD_BIT   = 6;
    localparam int         FLT_VIN_BIT  = 5;
    localparam int         FLT_TSD_BIT  = 4;
    localparam int         FLT_BAT_BIT  = 3;
    localparam int         FLT_TMR_BIT  = 2;
    localparam int         FLT_HOT_BIT  = 1;
    localparam int         FLT_COLD_BIT = 0;
    localparam logic [7:0] FAULT_RESET  = 8'h00;

    // Junction regulation thresholds in degrees Celsius.
    localparam logic [7:0] TJ_60C  = 8'd60;
    localparam logic [7:0] TJ_80C  = 8'd80;
    localparam logic [7:0] TJ_100C = 8'd100;
    localparam logic [7:0] TJ_120C = 8'd120;

    // Charge state codes.
    localparam logic [1:0] CHG_IDLE = 2'b00;
    localparam logic [1:0] CHG_PRE  = 2'b01;
    localparam logic [1:0] CHG_FAST = 2'b10;
    localparam logic [1:0] CHG_DONE = 2'b11;

    // Watchdog limit codes; the period is a multiple of a 40 s base unit.
    localparam logic [1:0] WD_LIM_OFF  = 2'b00;
    localparam logic [1:0] WD_LIM_40S  = 2'b01;
    localparam logic [1:0] WD_LIM_80S  = 2'b10;
    localparam logic [1:0] WD_LIM_160S = 2'b11;
    localparam longint     CLK_HZ      = 40_000_000;
    localparam longint     WD_BASE_S   = 40;
    localparam longint     WD_BASE_CYC = WD_BASE_S * CLK_HZ;

    // Step sizes of the one-time-programmable charge parameter codes.
    localparam int VREG_STEP_MV = 15;
    localparam int PRECHARGE_CURRENT_STEP_MA = 7;
    localparam int ICC_STEP_MA  = 17;

    // Live status conditions from the charging core.
    typedef struct packed {
        logic [1:0] charge_state;
        logic       power_path_active_flag;
        logic       input_power_good_flag;
        logic       thermal_regulation_flag;
    } cscr_status_t;

    // Live fault conditions from the protection circuits.
    typedef struct packed {
        logic input_source_fault;
        logic thermal_shutdown_flag;
        logic battery_overvoltage_fault;
        logic charge_timer_fault;
        logic thermistor_hot;
        logic thermistor_cold;
    } cscr_fault_t;

    // One-time-programmable defaults of the charge parameters.
    typedef struct packed {
        logic [4:0] fast_charge_current;
        logic [1:0] precharge_current;
        logic [5:0] battery_regulation_voltage;
        logic       board_overtemp_protection;
        logic [1:0] watchdog_limit;
    } cscr_otp_t;

endpackage

/* cscr_regs.sv */
/*
 * Charger status and control register tail: the miscellaneous control
 * register, the read-only status and fault registers, the host watchdog and
 * the capture of the one-time-programmable charge parameter defaults.
 * Assumes an I2C front end that has already decoded register address and
 * data and presents one-cycle read and write strobes on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module cscr_regs #(
    parameter longint     WD_TICK_CYCLES = cscr_pkg::WD_BASE_CYC,
    parameter logic [1:0] REVISION       = 2'b01 // Arbitrary value.
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata,
    input  wire cscr_pkg::cscr_status_t status_in,
    input  wire cscr_pkg::cscr_fault_t  fault_in,
    input  wire cscr_pkg::cscr_otp_t    otp_in,
    input  wire logic                   input_present,
    input  wire logic                   watchdog_kick,
    output logic                        safety_timer_double,
    output logic                        battery_switch_off,
    output logic                        thermistor_monitor_on,
    output logic [7:0]                  junction_limit_c,
    output cscr_pkg::cscr_otp_t         charge_params,
    output logic                        watchdog_expired
);
    import cscr_pkg::*;

    // Watchdog states, one-hot.
    typedef enum logic [3:0] {
        WD_OFF  = 4'b0001,
        WD_RUN  = 4'b0010,
        WD_HOLD = 4'b0100,
        WD_EXP  = 4'b1000
    } cscr_wd_state_t;

    // Width of the base tick counter, enough for the longest base unit.
    localparam int TW = $clog2(WD_TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(WD_TICK_CYCLES - 1);

    // Maps the threshold code to degrees Celsius.
    function automatic logic [7:0] tj_celsius(input logic [1:0] code);
        unique case (code)
            2'b00: tj_celsius = TJ_60C;
            2'b01: tj_celsius = TJ_80C;
            2'b10: tj_celsius = TJ_100C;
            2'b11: tj_celsius = TJ_120C;
        endcase
    endfunction

    // Number of 40 s base units for a watchdog limit code.
    function automatic logic [2:0] wd_units(input logic [1:0] code);
        unique case (code)
            WD_LIM_OFF:  wd_units = 3'h0;
            WD_LIM_40S:  wd_units = 3'h1;
            WD_LIM_80S:  wd_units = 3'h2;
            WD_LIM_160S: wd_units = 3'h4;
        endcase
    endfunction

    logic [7:0]     misc_q;     // Control register, writable bits only.
    logic [7:0]     misc_d;     // Next control register value.
    logic [7:0]     rdata_q;    // Read data, held until the next read.
    logic [7:0]     rdata_d;    // Next read data.
    cscr_otp_t      params_q;   // Captured charge parameter defaults.
    cscr_wd_state_t wd_q;       // Watchdog state.
    cscr_wd_state_t wd_d;       // Next watchdog state.
    logic [TW-1:0]  tick_q;     // Cycles within the current base unit.
    logic [TW-1:0]  tick_d;     // Next tick count.
    logic [2:0]     unit_q;     // Base units elapsed.
    logic [2:0]     unit_d;     // Next unit count.

    // Decodes of the register strobes and addresses, and of the watchdog limit and counts.
    wire        wr_misc   = reg_wr && (reg_addr == MISC_OFFSET);
    wire        hit_misc  = (reg_addr == MISC_OFFSET);
    wire        hit_stat  = (reg_addr == STATUS_OFFSET);
    wire        hit_fault = (reg_addr == FAULT_OFFSET);
    wire [2:0]  wd_lim_u  = wd_units(params_q.watchdog_limit);
    wire        wd_enable = (wd_lim_u != 3'h0);
    wire        tick_end  = (tick_q == TICK_LAST);
    wire        unit_end  = tick_end && ((unit_q + 3'h1) == wd_lim_u);

    // Control register update; reserved bits never store anything.
    assign misc_d = wr_misc ? (reg_wdata & MISC_WRITE_MASK) : misc_q;

    // Status image built straight from the live conditions.
    wire [7:0] status_img = {1'b0, REVISION,
        status_in.charge_state,
        status_in.power_path_active_flag,
        status_in.input_power_good_flag,
        status_in.thermal_regulation_flag};

    // Thermistor faults are hidden while monitoring is switched off.
    wire       ntc_on = misc_q[MISC_NTC_BIT];
    // Live fault image; only the watchdog bit has memory.
    wire [7:0] fault_img = {1'b0,
        (wd_q == WD_EXP),
        fault_in.input_source_fault,
        fault_in.thermal_shutdown_flag,
        fault_in.battery_overvoltage_fault,
        fault_in.charge_timer_fault,
        fault_in.thermistor_hot && ntc_on,
        fault_in.thermistor_cold && ntc_on};

    // Read mux; unmapped addresses answer zero.
    // The answer waits in rdata_q until the next read strobe.
    assign rdata_d = !reg_rd  ? rdata_q :
                     hit_misc ? misc_q :
                     hit_stat ? status_img :
                     hit_fault ? fault_img : 8'h00;

    // Watchdog sequencing. Once expired it stays expired and stops
    // counting until the host kicks it, so a missed kick cannot be hidden.
    always_comb begin
        wd_d   = wd_q;
        tick_d = tick_q;
        unit_d = unit_q;
        unique case (wd_q)
            WD_OFF: begin
                tick_d = '0;
                unit_d = 3'h0;
                if (wd_enable) begin
                    wd_d = input_present ? WD_RUN : WD_HOLD;
                end
            end
            WD_RUN: begin
                // A kick on the last counting cycle wins over expiry, so a
                // host that is just in time is never flagged.
                if (!wd_enable) begin
                    wd_d = WD_OFF;
                end else if (watchdog_kick) begin
                    tick_d = '0;
                    unit_d = 3'h0;
                end else if (!input_present) begin
                    wd_d = WD_HOLD;
                end else if (unit_end) begin
                    wd_d = WD_EXP;
                end else if (tick_end) begin
                    tick_d = '0;
                    unit_d = unit_q + 3'h1;
                end else begin
                    tick_d = tick_q + TW'(1);
                end
            end
            WD_HOLD: begin
                // Counts are frozen while the input is gone; only a kick clears them.
                if (!wd_enable) begin
                    wd_d = WD_OFF;
                end else if (watchdog_kick) begin
                    tick_d = '0;
                    unit_d = 3'h0;
                end else if (input_present) begin
                    wd_d = WD_RUN;
                end
            end
            WD_EXP: begin
                if (watchdog_kick) begin
                    wd_d   = WD_OFF;
                    tick_d = '0;
                    unit_d = 3'h0;
                end
            end
            default: begin
                wd_d = WD_OFF;
            end
        endcase
    end

    // Register state; the OTP defaults are taken while reset is held.
    // Reset is synchronous, so otp_in must be steady at the reset edges.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            misc_q   <= MISC_RESET;
            rdata_q  <= 8'h00;
            params_q <= otp_in;
            wd_q     <= WD_OFF;
            tick_q   <= '0;
            unit_q   <= 3'h0;
        end else begin
            misc_q  <= misc_d;
            rdata_q <= rdata_d;
            wd_q    <= wd_d;
            tick_q  <= tick_d;
            unit_q  <= unit_d;
        end
    end

    // Control outputs derived from the control register, then the parameter, watchdog and read data outputs.
    assign safety_timer_double = misc_q[MISC_TMR2X_BIT]
        && status_in.power_path_active_flag;
    assign battery_switch_off    = misc_q[MISC_BSW_BIT];
    assign thermistor_monitor_on = ntc_on;
    assign junction_limit_c = tj_celsius(misc_q[MISC_TJ_LSB +: 2]);
    assign charge_params    = params_q;
    assign watchdog_expired = (wd_q == WD_EXP);
    assign reg_rdata        = rdata_q;

    // Checks on the block's outputs and internal registers.
    // All checks share clk and are switched off while reset is held.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_double_timer: assert property (
        wr_misc |=> safety_timer_double ==
            ($past(reg_wdata[MISC_TMR2X_BIT])
            && status_in.power_path_active_flag))
        else $error("Safety timer doubling wrong.");
    chk_misc_write: assert property (
        wr_misc |=> misc_q == ($past(reg_wdata) & MISC_WRITE_MASK))
        else $error("Control write not stored.");
    chk_tj_map: assert property (
        misc_q[1:0] == 2'b11 |-> junction_limit_c == TJ_120C)
        else $error("Junction threshold mapping wrong.");
    chk_reset_misc: assert property (
        $rose(rst_b) |-> misc_q == MISC_RESET)
        else $error("Control register reset value wrong.");
    chk_status_read: assert property (
        reg_rd && hit_stat |=> reg_rdata[4:0] == $past(status_img[4:0]))
        else $error("Status read wrong.");
    chk_ntc_mask: assert property (
        reg_rd && hit_fault && !ntc_on |=> reg_rdata[1:0] == 2'b00)
        else $error("Thermistor fault shown while disabled.");
    chk_reserved_zero: assert property (
        reg_rd |=> reg_rdata[7] == 1'b0)
        else $error("Reserved bit read nonzero.");
    chk_wd_hold: assert property (
        wd_q == WD_HOLD && !watchdog_kick |=> $stable(tick_q))
        else $error("Watchdog counted without input.");
    chk_wd_sticky: assert property (
        watchdog_expired && !watchdog_kick |=> watchdog_expired)
        else $error("Watchdog expiry cleared without kick.");
    chk_wd_expire: assert property (
        wd_q == WD_RUN && input_present && !watchdog_kick && unit_end
        && wd_enable |=> watchdog_expired)
        else $error("Watchdog did not expire.");

    // The other three threshold codes, so a swapped pair is caught.
    chk_tj_lowest: assert property (
        misc_q[1:0] == 2'b00 |-> junction_limit_c == TJ_60C)
        else $error("Junction threshold 60 wrong.");
    chk_tj_second: assert property (
        misc_q[1:0] == 2'b01 |-> junction_limit_c == TJ_80C)
        else $error("Junction threshold 80 wrong.");
    chk_tj_third: assert property (
        misc_q[1:0] == 2'b10 |-> junction_limit_c == TJ_100C)
        else $error("Junction threshold 100 wrong.");

    // A control write must reach the pins on the very next cycle.
    chk_switch_write: assert property (
        wr_misc |=> battery_switch_off == $past(reg_wdata[MISC_BSW_BIT]))
        else $error("Battery switch control not applied.");
    chk_ntc_write: assert property (
        wr_misc |=> thermistor_monitor_on == $past(reg_wdata[MISC_NTC_BIT]))
        else $error("Thermistor enable not applied.");

    // Writes elsewhere, read-only or unmapped, leave the control alone.
    chk_misc_hold: assert property (
        !wr_misc |=> $stable(misc_q))
        else $error("Control register changed without a write.");

    // Fault reads carry the live conditions and the sticky watchdog bit.
    chk_fault_live: assert property (
        reg_rd && hit_fault |=> reg_rdata[5:2] == $past(fault_in[5:2]))
        else $error("Fault read does not follow conditions.");
    chk_wd_fault_bit: assert property (
        reg_rd && hit_fault |=> reg_rdata[6] == $past(watchdog_expired))
        else $error("Watchdog fault bit wrong.");

    // Main scenarios that the bench is expected to reach.
    cov_wd_expiry: cover property (wd_q == WD_RUN ##1 wd_q == WD_EXP);
    cov_wd_hold:   cover property (wd_q == WD_RUN ##1 wd_q == WD_HOLD);
    cov_misc_wr:   cover property (wr_misc ##1 battery_switch_off);
    cov_fault_rd:  cover property (reg_rd && hit_fault);
    cov_wd_kick:   cover property (watchdog_expired && watchdog_kick);

endmodule

`default_nettype wire

/* cscr_host.sv */
/*
 * Behavioural model of the host processor that sits behind the I2C front
 * end and reaches the register tail with decoded byte strobes.
 * Assumes the bench calls its tasks and that all signals share clk.
 */
`timescale 1ns/10ps
`default_nettype none

module cscr_host (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    output logic            watchdog_kick
);
    // Idle values at time zero; no strobe before the reset is released.
    initial begin
        reg_addr      = 8'h00;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
        reg_wdata     = 8'h00;
        watchdog_kick = 1'b0;
    end

    // One byte write; address and data are scrambled once the strobe drops
    // so that a design reading them late cannot see a stale match.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // One byte read; the data is taken an edge later, since it holds.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // One-cycle watchdog kick pulse that restarts the watchdog.
    task automatic kick();
        @(posedge clk);
        watchdog_kick <= 1'b1;
        @(posedge clk);
        watchdog_kick <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* tb_top.sv */
/*
 * Self-checking bench for the charger register tail.
 * Assumes the host model file and the design package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import cscr_pkg::*;
    localparam logic [1:0] REV = 2'b01; // Arbitrary value.
    logic clk, rst_b, input_present;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, junction_limit_c, d;
    logic reg_wr, reg_rd, watchdog_kick, watchdog_expired;
    logic safety_timer_double, battery_switch_off, thermistor_monitor_on;
    cscr_status_t status_in;
    cscr_fault_t fault_in;
    cscr_otp_t otp_in, charge_params;
    int bad_count, num_checks;

    // A short watchdog tick keeps the long timer periods reachable.
    cscr_regs #(.WD_TICK_CYCLES(4), .REVISION(REV)) dut (.clk(clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .status_in(status_in), .fault_in(fault_in), .otp_in(otp_in),
        .input_present(input_present), .watchdog_kick(watchdog_kick),
        .safety_timer_double(safety_timer_double),
        .battery_switch_off(battery_switch_off),
        .thermistor_monitor_on(thermistor_monitor_on),
        .junction_limit_c(junction_limit_c),
        .charge_params(charge_params), .watchdog_expired(watchdog_expired));
    cscr_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .watchdog_kick(watchdog_kick));

    // 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reset for six cycles with a chosen OTP image, return after release.
    task automatic do_reset(input logic [1:0] lim);
        @(posedge clk);
        otp_in <= {14'h2969, lim};
        rst_b  <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask

    task automatic t_reset_vals();
        host.rd(MISC_OFFSET, d);
        chk("misc reset", 8'h4b, d);
        chk("switch off", 1'b0, battery_switch_off);
        chk("ntc on", 1'b1, thermistor_monitor_on);
        chk("tj limit", TJ_120C, junction_limit_c);
        chk("otp", otp_in, charge_params);
        host.rd(FAULT_OFFSET, d);
        chk("fault reset", 8'h00, d);
        host.rd(STATUS_OFFSET, d);
        chk("status reset", {1'b0, REV, 5'h00}, d);
    endtask

    task automatic t_misc();
        logic [7:0] tj [4] = '{8'd60, 8'd80, 8'd100, 8'd120};
        host.wr(MISC_OFFSET, 8'hff);
        host.rd(MISC_OFFSET, d);
        chk("misc masked", 8'h6b, d);
        for (int i = 0; i < 4; i++) begin
            host.wr(MISC_OFFSET, 8'(i));
            @(posedge clk);
            chk("tj code", tj[i], junction_limit_c);
        end
        host.wr(MISC_OFFSET, 8'h20);
        status_in.power_path_active_flag <= 1'b1;
        @(posedge clk);
        #1 chk("switch", 1'b1, battery_switch_off);
        chk("ntc off", 1'b0, thermistor_monitor_on);
        chk("no double", 1'b0, safety_timer_double);
        host.wr(MISC_OFFSET, 8'h48);
        @(posedge clk);
        #1 chk("double", 1'b1, safety_timer_double);
        chk("switch on", 1'b0, battery_switch_off);
        @(posedge clk);
        status_in.power_path_active_flag <= 1'b0;
        @(posedge clk);
        #1 chk("double ppm off", 1'b0, safety_timer_double);
    endtask

    // Every charge state with every flag pattern; writes must not stick.
    task automatic t_status();
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            status_in <= 5'(i);
            host.rd(STATUS_OFFSET, d);
            chk("status", {1'b0, REV, 5'(i)}, d);
        end
        host.wr(STATUS_OFFSET, 8'h00);
        host.rd(STATUS_OFFSET, d);
        chk("status ro", {1'b0, REV, 5'h1f}, d);
    endtask

    task automatic t_fault();
        host.wr(MISC_OFFSET, 8'h08);
        for (int b = 0; b < 6; b++) begin
            @(posedge clk);
            fault_in <= 6'h01 << b;
            host.rd(FAULT_OFFSET, d);
            chk("fault bit", 8'h01 << b, d);
        end
        @(posedge clk);
        fault_in <= 6'h00;
        host.wr(FAULT_OFFSET, 8'hff);
        host.rd(FAULT_OFFSET, d);
        chk("fault clear", 8'h00, d);
        host.wr(MISC_OFFSET, 8'h00);
        fault_in <= 6'h3f;
        host.rd(FAULT_OFFSET, d);
        chk("ntc masked", 8'h3c, d);
        host.wr(8'h09, 8'hff);
        host.rd(8'h09, d);
        chk("unmapped", 8'h00, d);
        fault_in <= 6'h00;
    endtask

    // Each watchdog code from OTP, then the hold without input supply.
    task automatic t_watchdog();
        int n;
        for (int c = 0; c < 4; c++) begin
            do_reset(2'(c));
            chk("otp capture", otp_in, charge_params);
            n = 0;
            while (watchdog_expired !== 1'b1 && n < 80) begin
                @(posedge clk);
                #1 n++;
            end
            if (c == 0) begin
                chk("wd off", 16'd80, 16'(n));
            end else begin
                chk("wd period", 16'd1,
                    16'(n >= (4 << (c - 1)) && n <= (4 << (c - 1)) + 2));
                host.rd(FAULT_OFFSET, d);
                chk("wd fault", 8'h40, d);
                host.kick();
                @(posedge clk);
                #1 chk("wd cleared", 1'b0, watchdog_expired);
            end
        end
        @(posedge clk);
        input_present <= 1'b0;
        host.kick();
        repeat (40) @(posedge clk);
        #1 chk("wd held", 1'b0, watchdog_expired);
        @(posedge clk);
        input_present <= 1'b1;
        repeat (20) @(posedge clk);
        #1 chk("wd resumes", 1'b1, watchdog_expired);
    endtask

    initial begin
        #300_000;
        bad_count++;
        complete_run();
    end

    initial begin
        bad_count     = 0;
        num_checks    = 0;
        rst_b         = 1'b0;
        input_present = 1'b1;
        status_in     = '0;
        fault_in      = '0;
        otp_in        = {14'h2969, 2'b00};
        do_reset(2'b00);
        t_reset_vals();
        t_misc();
        t_status();
        t_fault();
        t_watchdog();
        complete_run();
    end
endmodule

`default_nettype wire
